// File: rtl/pwl_ctrl.sv
// Overview of operation
// [R01] show tx banner at every wake while the pulse weight is unset
// [R02] first flow pulse fixes the weight for good; nothing alters it later
// [R03] pulse before confirmation keeps the default weight of one liter
// [R04] brief press while unset advances the candidate weight
// [R05] press over four seconds while unset confirms the candidate
// [R06] readout decimals follow the weight; kwh allowed only at one liter
// [R07] sensor-missing code shown until sensors present and first measure
// [R08] with no flow, measure temperature every fifteen minutes
// [R09] display off normally; button press wakes it for two minutes
// [R10] energy unit and install point writable once before operation
// [R11] glycol settings writable any time from the configuration tool
// [R12] every loop shows the install point indicator
// [R13] long press in normal use steps loop; short press steps item
// [R14] candidate wraps at the top; brief means released before threshold
`timescale 1ns/100ps
`default_nettype none
`include "pwl_params.svh"
module pwl_ctrl #(
  parameter logic [39:0] LONG_CYC = 40'(`PWL_LONG_CYC),
  parameter logic [39:0] WAKE_CYC = 40'(`PWL_WAKE_CYC),
  parameter logic [39:0] MEAS_CYC = 40'(`PWL_MEAS_CYC)
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic button,
  input wire logic flow_pulse,
  input wire logic sensors_present,
  input wire logic meas_done,
  input wire logic cfg_write,
  input wire logic cfg_energy_unit,
  input wire logic cfg_outlet_point,
  input wire logic cfg_glycol_write,
  input wire logic [3:0] cfg_glycol_type,
  input wire logic [7:0] cfg_glycol_conc,
  output logic weight_locked,
  output var pwl_pkg::pwl_weight_t weight,
  output logic display_on,
  output var pwl_pkg::pwl_disp_t disp,
  output logic meas_req,
  output logic [3:0] glycol_type,
  output logic [7:0] glycol_conc
);
  pwl_pkg::pwl_btn_ev_t ev;
  logic long_seen;

  pwl_button #(.LONG_CYC(LONG_CYC)) u_btn (
    .clk(clk),
    .nrst(nrst),
    .button(button),
    .ev(ev),
    .long_seen(long_seen)
  );

  logic press_edge;
  logic btn_d;
  logic flow_seen;
  logic setup_locked;
  logic first_meas;
  logic [39:0] wake_cnt;
  logic [39:0] meas_cnt;
  logic next_locked;
  pwl_pkg::pwl_weight_t next_weight;
  logic next_display_on;
  logic [39:0] next_wake_cnt;
  logic [39:0] next_meas_cnt;
  logic next_meas_req;
  logic next_flow_seen;
  logic next_setup_locked;
  logic next_first_meas;
  logic next_btn_d;
  pwl_pkg::pwl_disp_t next_disp;
  logic [3:0] next_glycol_type;
  logic [7:0] next_glycol_conc;

  assign press_edge = button && !btn_d;

  always_comb begin
    next_btn_d = button;
    next_locked = weight_locked;
    next_weight = weight;
    next_flow_seen = flow_seen | flow_pulse;
    next_setup_locked = setup_locked;
    next_first_meas = first_meas;
    next_display_on = display_on;
    next_wake_cnt = wake_cnt;
    next_meas_cnt = meas_cnt;
    next_meas_req = 1'b0;
    next_disp = disp;
    next_glycol_type = glycol_type;
    next_glycol_conc = glycol_conc;
    // flow before confirm drops the candidate: meter fixed at one liter
    if (!weight_locked) begin
      if (flow_pulse) begin
        next_locked = 1'b1; // see [R02] [R03]
        next_weight = pwl_pkg::pwl_weight_t'(`PWL_SEL_DEFAULT);
      end else if (ev.long_press) begin
        next_locked = 1'b1; // see [R05]
      end else if (ev.short_press && display_on) begin
        next_weight = (weight == pwl_pkg::pwl_weight_t'(`PWL_SEL_LAST)) ?
          pwl_pkg::pwl_weight_t'(`PWL_SEL_DEFAULT) :
          pwl_pkg::pwl_weight_t'(weight + 3'h1); // see [R04] [R14]
      end
    end else if (display_on) begin
      if (ev.long_press) begin
        next_disp.loop_idx = (disp.loop_idx == `PWL_LOOP_LAST) ?
          3'h0 : disp.loop_idx + 3'h1; // see [R13]
        next_disp.item_idx = 3'h0;
      end else if (ev.short_press) begin
        next_disp.item_idx = disp.item_idx + 3'h1; // see [R13]
      end
    end
    // one-shot setup: first flow pulse counts as start of operation
    if (flow_pulse) begin
      next_setup_locked = 1'b1; // see [R10]
    end
    if (cfg_write && !setup_locked && !flow_pulse) begin
      next_disp.energy_unit = cfg_energy_unit; // see [R10]
      next_disp.outlet_point = cfg_outlet_point;
      next_setup_locked = 1'b1;
    end
    if (cfg_glycol_write) begin
      next_glycol_type = cfg_glycol_type; // see [R11]
      next_glycol_conc = cfg_glycol_conc;
    end
    if (press_edge) begin
      next_display_on = 1'b1; // see [R09]
      next_wake_cnt = WAKE_CYC;
    end else if (display_on) begin
      if (wake_cnt <= 40'h1) begin
        next_display_on = 1'b0;
        next_wake_cnt = '0;
      end else begin
        next_wake_cnt = wake_cnt - 40'h1;
      end
    end
    // long hold keeps display awake through loop stepping
    if (long_seen && button) begin
      next_wake_cnt = WAKE_CYC;
    end
    if (flow_pulse) begin
      next_meas_cnt = '0;
    end else if (meas_cnt >= MEAS_CYC - 40'h1) begin
      next_meas_cnt = '0;
      next_meas_req = 1'b1; // see [R08]
    end else begin
      next_meas_cnt = meas_cnt + 40'h1;
    end
    if (meas_done && sensors_present) begin
      next_first_meas = 1'b1;
    end
    next_disp.sensor_missing = !(sensors_present && next_first_meas); // see [R07]
    next_disp.tx_banner = next_display_on && !next_locked; // see [R01]
    case (next_weight)
      pwl_pkg::PWL_W1, pwl_pkg::PWL_W2P5: next_disp.decimals = 2'h3; // see [R06]
      pwl_pkg::PWL_W10, pwl_pkg::PWL_W25: next_disp.decimals = 2'h2;
      pwl_pkg::PWL_W100, pwl_pkg::PWL_W250: next_disp.decimals = 2'h1;
      default: next_disp.decimals = 2'h0;
    endcase
    next_disp.kwh_allowed = (next_weight == pwl_pkg::PWL_W1); // see [R06]
  end

  // install point bit always travels with disp to every loop, see [R12]
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      btn_d <= 1'b0;
      weight_locked <= 1'b0;
      weight <= pwl_pkg::pwl_weight_t'(`PWL_SEL_DEFAULT);
      flow_seen <= 1'b0;
      setup_locked <= 1'b0;
      first_meas <= 1'b0;
      display_on <= 1'b0;
      wake_cnt <= '0;
      meas_cnt <= '0;
      meas_req <= 1'b0;
      disp <= '{decimals: 2'h3, kwh_allowed: 1'b1, sensor_missing: 1'b1,
                default: '0};
      glycol_type <= 4'h0;
      glycol_conc <= 8'h00;
    end else begin
      btn_d <= next_btn_d;
      weight_locked <= next_locked;
      weight <= next_weight;
      flow_seen <= next_flow_seen;
      setup_locked <= next_setup_locked;
      first_meas <= next_first_meas;
      display_on <= next_display_on;
      wake_cnt <= next_wake_cnt;
      meas_cnt <= next_meas_cnt;
      meas_req <= next_meas_req;
      disp <= next_disp;
      glycol_type <= next_glycol_type;
      glycol_conc <= next_glycol_conc;
    end
  end

  property p_lock_stays;
    @(posedge clk) disable iff (!nrst)
    weight_locked |=> weight_locked && $stable(weight);
  endproperty
  a_lock_stays: assert property (p_lock_stays) // see [R02]
    else $error("weight changed after lock");

  property p_pulse_locks;
    @(posedge clk) disable iff (!nrst)
    (flow_pulse && !weight_locked) |=> weight_locked
      && weight == pwl_pkg::pwl_weight_t'(`PWL_SEL_DEFAULT);
  endproperty
  a_pulse_locks: assert property (p_pulse_locks) // see [R03]
    else $error("pulse did not lock default weight");

  property p_short_adv;
    @(posedge clk) disable iff (!nrst)
    (ev.short_press && display_on && !weight_locked && !flow_pulse
     && !ev.long_press) |=> weight != $past(weight);
  endproperty
  a_short_adv: assert property (p_short_adv) // see [R04]
    else $error("short press did not advance weight");

  property p_long_lock;
    @(posedge clk) disable iff (!nrst)
    ev.long_press |=> weight_locked;
  endproperty
  a_long_lock: assert property (p_long_lock) // see [R05]
    else $error("long press did not lock");

  property p_banner;
    @(posedge clk) disable iff (!nrst)
    disp.tx_banner == (display_on && !weight_locked);
  endproperty
  a_banner: assert property (p_banner) // see [R01]
    else $error("banner mismatch");

  property p_dec;
    @(posedge clk) disable iff (!nrst)
    disp.decimals == 2'h3 - 2'(weight >> 1)
      && disp.kwh_allowed == (weight == pwl_pkg::PWL_W1);
  endproperty
  a_dec: assert property (p_dec) // see [R06]
    else $error("decimals or kwh do not follow weight");

  property p_wake;
    @(posedge clk) disable iff (!nrst)
    press_edge |=> display_on;
  endproperty
  a_wake: assert property (p_wake) // see [R09]
    else $error("press did not wake display");

  property p_setup_once;
    @(posedge clk) disable iff (!nrst)
    setup_locked |=> $stable(disp.outlet_point) && $stable(disp.energy_unit);
  endproperty
  a_setup_once: assert property (p_setup_once) // see [R10]
    else $error("setup changed after lock");

  property p_sensor;
    @(posedge clk) disable iff (!nrst)
    !first_meas |-> disp.sensor_missing;
  endproperty
  a_sensor: assert property (p_sensor) // see [R07]
    else $error("sensor code dropped before first measure");
endmodule : pwl_ctrl
`default_nettype wire

// File: rtl/pwl_params.svh
`ifndef PWL_PARAMS_SVH
`define PWL_PARAMS_SVH
`define PWL_CLK_HZ 40'd250000000
`define PWL_LONG_PRESS_S 4
`define PWL_LONG_CYC (`PWL_LONG_PRESS_S * `PWL_CLK_HZ)
`define PWL_WAKE_S 120
`define PWL_WAKE_CYC (`PWL_WAKE_S * `PWL_CLK_HZ)
`define PWL_MEAS_S 900
`define PWL_MEAS_CYC (`PWL_MEAS_S * `PWL_CLK_HZ)
`define PWL_SEL_DEFAULT 3'h0
`define PWL_SEL_LAST 3'h7
`define PWL_LOOP_LAST 3'h4
`endif

// File: rtl/pwl_pkg.sv
package pwl_pkg;
  typedef enum logic [2:0] {
    PWL_W1, PWL_W2P5, PWL_W10, PWL_W25,
    PWL_W100, PWL_W250, PWL_W1000, PWL_W2500
  } pwl_weight_t;
  typedef struct packed {
    logic [1:0] decimals;
    logic kwh_allowed;
    logic tx_banner;
    logic sensor_missing;
    logic outlet_point;
    logic energy_unit;
    logic [2:0] loop_idx;
    logic [2:0] item_idx;
  } pwl_disp_t;
  typedef struct packed {
    logic short_press;
    logic long_press;
  } pwl_btn_ev_t;
endpackage : pwl_pkg

// File: rtl/pwl_button.sv
`timescale 1ns/100ps
`default_nettype none
`include "pwl_params.svh"
module pwl_button #(
  parameter logic [39:0] LONG_CYC = 40'(`PWL_LONG_CYC)
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic button,
  output var pwl_pkg::pwl_btn_ev_t ev,
  output logic long_seen
);
  logic [39:0] cnt;
  logic [39:0] next_cnt;
  logic held;
  logic next_held;
  logic next_long_seen;
  pwl_pkg::pwl_btn_ev_t next_ev;

  // long fires once at threshold while still held; short only on release
  always_comb begin
    next_cnt = cnt;
    next_held = button;
    next_long_seen = long_seen;
    next_ev = '0;
    if (button) begin
      if (!long_seen) begin
        if (cnt >= LONG_CYC) begin
          next_ev.long_press = 1'b1; // see [R05] [R13]
          next_long_seen = 1'b1;
        end else begin
          next_cnt = cnt + 40'h1;
        end
      end
    end else begin
      if (held && !long_seen) begin
        next_ev.short_press = 1'b1; // see [R14]
      end
      next_cnt = '0;
      next_long_seen = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= '0;
      held <= 1'b0;
      long_seen <= 1'b0;
      ev <= '0;
    end else begin
      cnt <= next_cnt;
      held <= next_held;
      long_seen <= next_long_seen;
      ev <= next_ev;
    end
  end
endmodule : pwl_button
`default_nettype wire

// File: verif/pwl_far.sv
`timescale 1ns/100ps
`default_nettype none
module pwl_far (
  input wire logic clk,
  output logic button,
  output logic flow_pulse
);
  // idle: button released, meter silent
  initial begin
    button = 1'b0;
    flow_pulse = 1'b0;
  end
  // hold n edges; n over the long threshold makes a long press
  task automatic press(input int n);
    @(posedge clk) #1 button = 1'b1;
    repeat (n) @(posedge clk);
    #1 button = 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask : press
  // one-cycle meter pulse, as an open-collector reed would give
  task automatic pulse();
    @(posedge clk) #1 flow_pulse = 1'b1;
    @(posedge clk) #1 flow_pulse = 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask : pulse
endmodule : pwl_far
`default_nettype wire

// File: verif/pulse_weight_lock_display_bench.sv
`timescale 1ns/100ps
`default_nettype none
module pulse_weight_lock_display_bench;
  logic clk, nrst, button, flow_pulse, sensors_present, meas_done;
  logic cfg_write, cfg_energy_unit, cfg_outlet_point, cfg_glycol_write;
  logic [3:0] cfg_glycol_type, glycol_type;
  logic [7:0] cfg_glycol_conc, glycol_conc;
  logic weight_locked, display_on, meas_req;
  pwl_pkg::pwl_weight_t weight;
  pwl_pkg::pwl_disp_t disp;
  logic [5:0] rows [8];
  int mismatches, num_checks, n;
  // short counts keep the run brief
  pwl_ctrl #(.LONG_CYC(40'd20), .WAKE_CYC(40'd200), .MEAS_CYC(40'd100)) DUT (
    .clk(clk), .nrst(nrst), .button(button), .flow_pulse(flow_pulse),
    .sensors_present(sensors_present), .meas_done(meas_done),
    .cfg_write(cfg_write), .cfg_energy_unit(cfg_energy_unit),
    .cfg_outlet_point(cfg_outlet_point), .cfg_glycol_write(cfg_glycol_write),
    .cfg_glycol_type(cfg_glycol_type), .cfg_glycol_conc(cfg_glycol_conc),
    .weight_locked(weight_locked), .weight(weight), .display_on(display_on),
    .disp(disp), .meas_req(meas_req), .glycol_type(glycol_type),
    .glycol_conc(glycol_conc)
  );
  pwl_far u_far (.clk(clk), .button(button), .flow_pulse(flow_pulse));
  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: flag %b not %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask : chk_val
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop
  task automatic do_reset();
    nrst = 1'b0;
    repeat (16) @(posedge clk);
    #1 nrst = 1'b1;
  endtask : do_reset
  task automatic cfg(input logic eu, input logic op);
    @(posedge clk) #1 cfg_write = 1'b1;
    cfg_energy_unit = eu;
    cfg_outlet_point = op;
    @(posedge clk) #1 cfg_write = 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : cfg
  task automatic gly(input logic [3:0] t, input logic [7:0] c);
    @(posedge clk) #1 cfg_glycol_write = 1'b1;
    cfg_glycol_type = t;
    cfg_glycol_conc = c;
    @(posedge clk) #1 cfg_glycol_write = 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : gly
  // bounded wait; returns edges counted up to the request
  task automatic wait_meas(output int k);
    k = 0;
    do begin
      @(posedge clk);
      #1 k++;
    end while (meas_req !== 1'b1 && k < 300);
  endtask : wait_meas
  // one measurement strobe with the sensors present or absent
  task automatic meas(input logic s);
    sensors_present = s;
    @(posedge clk) #1 meas_done = 1'b1;
    @(posedge clk) #1 meas_done = 1'b0;
    @(posedge clk) #1;
  endtask : meas
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #20000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    nrst = 1'b0;
    {sensors_present, meas_done, cfg_write, cfg_energy_unit, cfg_outlet_point,
     cfg_glycol_write, cfg_glycol_type, cfg_glycol_conc} = '0;
    // {weight, decimals, kwh} after each brief press; last row wraps
    rows = '{6'h0e, 6'h14, 6'h1c, 6'h22, 6'h2a, 6'h30, 6'h38, 6'h07};
    do_reset();
    chk_val(8'(weight), 8'h00);
    chk_bit(weight_locked, 1'b0);
    chk_bit(display_on, 1'b0);
    chk_bit(disp.tx_banner, 1'b0);
    chk_bit(meas_req, 1'b0);
    chk_val(8'(disp.decimals), 8'h03);
    chk_bit(disp.sensor_missing, 1'b1);
    foreach (rows[i]) begin
      u_far.press(3);
      chk_bit(display_on, 1'b1);
      chk_bit(disp.tx_banner, 1'b1);
      chk_val(8'(weight), 8'(rows[i][5:3]));
      chk_val(8'(disp.decimals), 8'(rows[i][2:1]));
      chk_bit(disp.kwh_allowed, rows[i][0]);
    end
    u_far.press(3);
    u_far.press(25);
    chk_bit(weight_locked, 1'b1);
    chk_val(8'(weight), 8'h01);
    chk_bit(disp.tx_banner, 1'b0);
    u_far.press(3);
    chk_val(8'(weight), 8'h01);
    u_far.pulse();
    chk_val(8'(weight), 8'h01);
    repeat (210) @(posedge clk);
    #1 chk_bit(display_on, 1'b0);
    do_reset();
    cfg(1'b1, 1'b1);
    chk_bit(disp.energy_unit, 1'b1);
    chk_bit(disp.outlet_point, 1'b1);
    cfg(1'b0, 1'b0);
    chk_bit(disp.energy_unit, 1'b1);
    chk_bit(disp.outlet_point, 1'b1);
    gly(4'h5, 8'h33);
    chk_val(8'(glycol_type), 8'h05);
    meas(1'b0);
    chk_bit(disp.sensor_missing, 1'b1);
    meas(1'b1);
    chk_bit(disp.sensor_missing, 1'b0);
    wait_meas(n);
    wait_meas(n);
    chk_val(8'(n), 8'h64);
    u_far.press(3);
    chk_val(8'(weight), 8'h01);
    chk_bit(disp.tx_banner, 1'b1);
    u_far.pulse();
    chk_bit(weight_locked, 1'b1);
    chk_val(8'(weight), 8'h00);
    chk_val(8'(disp.decimals), 8'h03);
    chk_bit(disp.tx_banner, 1'b0);
    gly(4'h9, 8'h80);
    chk_val(8'(glycol_type), 8'h09);
    chk_val(glycol_conc, 8'h80);
    u_far.press(3);
    u_far.press(25);
    chk_val(8'(disp.loop_idx), 8'h01);
    chk_val(8'(disp.item_idx), 8'h00);
    chk_val(8'(weight), 8'h00);
    u_far.press(3);
    chk_val(8'(disp.item_idx), 8'h01);
    chk_val(8'(disp.loop_idx), 8'h01);
    chk_bit(disp.outlet_point, 1'b1);
    report_and_stop();
  end
endmodule : pulse_weight_lock_display_bench
`default_nettype wire
